// ### design/canirq_pkg.sv
// package: register map, field positions and reset values for the CAN interrupt aggregator
package canirq_pkg;

	// ======================================================
	// sizes
	localparam int CANIRQ_SLOTS = 16;
	localparam int CANIRQ_ERRS = 3;
	localparam int CANIRQ_GROUPS = 3;
	localparam int CANIRQ_AW = 8;
	localparam int CANIRQ_DW = 32;
	localparam int CANIRQ_WAKE_CW = 8;

	// ======================================================
	// register byte offsets
	localparam logic [7:0] CANIRQ_OFS_CTRL = 8'h00;
	localparam logic [7:0] CANIRQ_OFS_SLOT_STAT = 8'h04;
	localparam logic [7:0] CANIRQ_OFS_ERR_STAT = 8'h08;
	localparam logic [7:0] CANIRQ_OFS_SLOT_MASK = 8'h0c;
	localparam logic [7:0] CANIRQ_OFS_ERR_MASK = 8'h10;
	localparam logic [7:0] CANIRQ_OFS_GRP_FLAG = 8'h14;
	localparam logic [7:0] CANIRQ_OFS_GRP_EN = 8'h18;
	localparam logic [7:0] CANIRQ_OFS_PENDING = 8'h1c;
	localparam logic [7:0] CANIRQ_OFS_WAKE = 8'h20;
	localparam logic [7:0] CANIRQ_OFS_SLOT_KIND = 8'h24;

	// ======================================================
	// field positions
	localparam int CANIRQ_CTRL_SPLIT = 0;
	localparam int CANIRQ_CTRL_WROUTE = 1;
	localparam int CANIRQ_ERR_BUS = 0;
	localparam int CANIRQ_ERR_PASSIVE = 1;
	localparam int CANIRQ_ERR_BUSOFF = 2;
	localparam int CANIRQ_GRP_RX = 0;
	localparam int CANIRQ_GRP_TX = 1;
	localparam int CANIRQ_GRP_ERR = 2;
	localparam int CANIRQ_WAKE_TMR = 0;
	localparam int CANIRQ_WAKE_EXT = 1;
	localparam int CANIRQ_WAKE_CNT_LSB = 8;

	// ======================================================
	// reset values
	localparam logic [1:0] CANIRQ_CTRL_RST = 2'h0;
	localparam logic [15:0] CANIRQ_SLOT_RST = 16'h0000;
	localparam logic [2:0] CANIRQ_ERR_RST = 3'h0;
	localparam logic [2:0] CANIRQ_GRP_RST = 3'h0;
	localparam logic [1:0] CANIRQ_WAKE_RST = 2'h0;
	localparam logic [7:0] CANIRQ_WCNT_RST = 8'h00;

endpackage

// ### design/canirq_top.sv
// can interrupt aggregator: status latching, masking, request routing and group flags
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps

// Summary of operation
// - latch tx and rx completion per slot
// - latch bus error, passive, bus-off
// - split select low: one ORed request
// - split select high: three category requests
// - combined request follows masked status bits
// - combined rising edge sets all flags
// - combined edge sets enabled pending bits
// - held combined request makes no edge
// - software clears status and flags
// - combined re-arms after flags, status clear
// - masked reception raises receive request
// - masked transmission raises transmit request
// - masked error event raises error request
// - receive edge sets flag, first pending
// - transmit edge sets flag, second pending
// - error edge sets flag, third pending
// - held error request changes nothing
// - rx/tx re-arm when flag cleared
// - error re-arms after flag, status clear
// - wake-up from receive pin activity
// - transmit completion sets slot status bit
module canirq_top #(
	parameter int SLOTS = canirq_pkg::CANIRQ_SLOTS,
	parameter int WAKE_CW = canirq_pkg::CANIRQ_WAKE_CW
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	// register port
	input wire logic [canirq_pkg::CANIRQ_AW-1:0] reg_addr,
	input wire logic [canirq_pkg::CANIRQ_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [canirq_pkg::CANIRQ_DW-1:0] reg_rdata,
	// protocol engine events, same clock, one-cycle pulses
	input wire logic [SLOTS-1:0] slot_tx_done,
	input wire logic [SLOTS-1:0] slot_rx_done,
	input wire logic bus_error_evt,
	input wire logic err_passive_evt,
	input wire logic bus_off_evt,
	// shared receive pin, asynchronous
	input wire logic can_receive_pin,
	// requests toward the cpu interrupt controller
	output logic combined_request,
	output logic receive_request,
	output logic transmit_request,
	output logic error_request,
	output logic [canirq_pkg::CANIRQ_GROUPS-1:0] group_request_flag,
	output logic [canirq_pkg::CANIRQ_GROUPS-1:0] pending_request_bit,
	output logic wake_request
);
	import canirq_pkg::*;

	// ======================================================
	// helpers
	function automatic logic [CANIRQ_DW-1:0] pad_word(input logic [SLOTS-1:0] v);
		logic [CANIRQ_DW-1:0] w;
		w = '0;
		w[SLOTS-1:0] = v;
		return w;
	endfunction

	// write-zero-to-clear with hardware set winning
	function automatic logic [SLOTS-1:0] w0c_slot(input logic [SLOTS-1:0] cur,
		input logic [SLOTS-1:0] set, input logic hit, input logic [SLOTS-1:0] wd);
		logic [SLOTS-1:0] clr;
		clr = hit ? ~wd : '0;
		return (cur & ~clr) | set;
	endfunction

	function automatic logic [2:0] w0c_3(input logic [2:0] cur, input logic [2:0] set,
		input logic hit, input logic [2:0] wd);
		logic [2:0] clr;
		clr = hit ? ~wd : 3'h0;
		return (cur & ~clr) | set;
	endfunction

	// ======================================================
	// registers
	logic [1:0] can_control_one_reg;
	logic [SLOTS-1:0] slot_irq_status_reg;
	logic [SLOTS-1:0] slot_kind_rx_reg;
	logic [2:0] error_irq_status_reg;
	logic [SLOTS-1:0] slot_irq_mask_reg;
	logic [2:0] error_irq_mask_reg;
	logic [2:0] group_flag_reg;
	logic [2:0] group_request_enable_reg;
	logic [2:0] pending_reg;
	logic [2:0] hold_reg;
	logic comb_hold_reg;
	logic [1:0] wake_flag_reg;
	logic [WAKE_CW-1:0] wake_count_reg;
	logic pin_s1_reg;
	logic pin_s2_reg;
	logic pin_s3_reg;
	logic [CANIRQ_DW-1:0] rdata_reg;

	logic split_mode;
	logic wr_ctrl, wr_slot_stat, wr_err_stat, wr_slot_mask, wr_err_mask;
	logic wr_grp_flag, wr_grp_en, wr_pending, wr_wake;
	logic [2:0] err_evt;
	logic [SLOTS-1:0] slot_set;
	logic rx_evt_masked, tx_evt_masked, err_level, comb_level;
	logic [2:0] split_trig;
	logic comb_trig;
	logic [2:0] flag_set, pend_set;
	logic pin_fall;
	logic [1:0] wake_set;

	assign split_mode = can_control_one_reg[CANIRQ_CTRL_SPLIT];

	// ======================================================
	// address decode
	assign wr_ctrl = reg_wr && reg_addr == CANIRQ_OFS_CTRL;
	assign wr_slot_stat = reg_wr && reg_addr == CANIRQ_OFS_SLOT_STAT;
	assign wr_err_stat = reg_wr && reg_addr == CANIRQ_OFS_ERR_STAT;
	assign wr_slot_mask = reg_wr && reg_addr == CANIRQ_OFS_SLOT_MASK;
	assign wr_err_mask = reg_wr && reg_addr == CANIRQ_OFS_ERR_MASK;
	assign wr_grp_flag = reg_wr && reg_addr == CANIRQ_OFS_GRP_FLAG;
	assign wr_grp_en = reg_wr && reg_addr == CANIRQ_OFS_GRP_EN;
	assign wr_pending = reg_wr && reg_addr == CANIRQ_OFS_PENDING;
	assign wr_wake = reg_wr && reg_addr == CANIRQ_OFS_WAKE;

	// ======================================================
	// event capture
	// both completion kinds
	assign slot_set = slot_tx_done | slot_rx_done;
	assign err_evt = {bus_off_evt, err_passive_evt, bus_error_evt};

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			slot_irq_status_reg <= CANIRQ_SLOT_RST;
		end else if (clk_en) begin
			slot_irq_status_reg <= w0c_slot(slot_irq_status_reg, slot_set, wr_slot_stat,
				reg_wdata[SLOTS-1:0]);
		end
	end

	// remembers which completion kind last set each slot, readable at the slot kind offset; split routing uses the event pulses directly
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			slot_kind_rx_reg <= CANIRQ_SLOT_RST;
		end else if (clk_en) begin
			slot_kind_rx_reg <= (slot_kind_rx_reg & ~slot_set) | slot_rx_done;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			error_irq_status_reg <= CANIRQ_ERR_RST;
		end else if (clk_en) begin
			error_irq_status_reg <= w0c_3(error_irq_status_reg, err_evt, wr_err_stat,
				reg_wdata[2:0]);
		end
	end

	// ======================================================
	// plain control registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			can_control_one_reg <= CANIRQ_CTRL_RST;
		end else if (clk_en && wr_ctrl) begin
			can_control_one_reg <= reg_wdata[1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			slot_irq_mask_reg <= CANIRQ_SLOT_RST;
			error_irq_mask_reg <= CANIRQ_ERR_RST;
			group_request_enable_reg <= CANIRQ_GRP_RST;
		end else if (clk_en) begin
			if (wr_slot_mask) begin
				slot_irq_mask_reg <= reg_wdata[SLOTS-1:0];
			end
			if (wr_err_mask) begin
				error_irq_mask_reg <= reg_wdata[2:0];
			end
			if (wr_grp_en) begin
				group_request_enable_reg <= reg_wdata[2:0];
			end
		end
	end

	// ======================================================
	// request levels
	// masked status drives combined level
	assign comb_level = |(slot_irq_status_reg & slot_irq_mask_reg)
		| |(error_irq_status_reg & error_irq_mask_reg);
	assign rx_evt_masked = |(slot_rx_done & slot_irq_mask_reg);
	assign tx_evt_masked = |(slot_tx_done & slot_irq_mask_reg);
	assign err_level = |(error_irq_status_reg & error_irq_mask_reg);

	assign split_trig[CANIRQ_GRP_RX] = split_mode && rx_evt_masked && !hold_reg[CANIRQ_GRP_RX];
	assign split_trig[CANIRQ_GRP_TX] = split_mode && tx_evt_masked && !hold_reg[CANIRQ_GRP_TX];
	assign split_trig[CANIRQ_GRP_ERR] = split_mode && err_level && !hold_reg[CANIRQ_GRP_ERR];

	// single OR, no edge while held
	assign comb_trig = !split_mode && comb_level && !comb_hold_reg;

	// split hold: receive/transmit stay high until their flag is cleared,
	// error stays high until both its flag and its masked status are clear
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hold_reg <= CANIRQ_GRP_RST;
		end else if (clk_en) begin
			hold_reg[CANIRQ_GRP_RX] <= split_mode && (split_trig[CANIRQ_GRP_RX]
				|| (hold_reg[CANIRQ_GRP_RX] && group_flag_reg[CANIRQ_GRP_RX]));
			hold_reg[CANIRQ_GRP_TX] <= split_mode && (split_trig[CANIRQ_GRP_TX]
				|| (hold_reg[CANIRQ_GRP_TX] && group_flag_reg[CANIRQ_GRP_TX]));
			// error needs flag and status clear
			hold_reg[CANIRQ_GRP_ERR] <= split_mode && (split_trig[CANIRQ_GRP_ERR]
				|| (hold_reg[CANIRQ_GRP_ERR]
				&& (group_flag_reg[CANIRQ_GRP_ERR] || err_level)));
		end
	end

	// combined blocks until flags and status clear
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			comb_hold_reg <= 1'b0;
		end else if (clk_en) begin
			comb_hold_reg <= !split_mode && (comb_trig
				|| (comb_hold_reg && (comb_level || |group_flag_reg)));
		end
	end

	// ======================================================
	// group flags and pending bits
	always_comb begin
		if (split_mode) begin
			flag_set = split_trig;
		end else begin
			flag_set = {CANIRQ_GROUPS{comb_trig}};
		end
	end

	assign pend_set = flag_set & group_request_enable_reg;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			group_flag_reg <= CANIRQ_GRP_RST;
		end else if (clk_en) begin
			group_flag_reg <= w0c_3(group_flag_reg, flag_set, wr_grp_flag, reg_wdata[2:0]);
		end
	end

	// pending bits stand in for the cpu controller's request bits;
	// the cpu side may also clear them here by writing zero
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pending_reg <= CANIRQ_GRP_RST;
		end else if (clk_en) begin
			pending_reg <= w0c_3(pending_reg, pend_set, wr_pending, reg_wdata[2:0]);
		end
	end

	// ======================================================
	// wake-up from the shared receive pin
	// the second and third stages feed the edge detector
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_reg <= 1'b1;
			pin_s2_reg <= 1'b1;
			pin_s3_reg <= 1'b1;
		end else if (clk_en) begin
			pin_s1_reg <= can_receive_pin;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end

	// recessive to dominant transition marks bus activity
	assign pin_fall = pin_s3_reg && !pin_s2_reg;

	// route by which pin carries receive
	assign wake_set[CANIRQ_WAKE_TMR] = pin_fall && !can_control_one_reg[CANIRQ_CTRL_WROUTE];
	assign wake_set[CANIRQ_WAKE_EXT] = pin_fall && can_control_one_reg[CANIRQ_CTRL_WROUTE];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wake_flag_reg <= CANIRQ_WAKE_RST;
		end else if (clk_en) begin
			if (wr_wake) begin
				wake_flag_reg <= (wake_flag_reg & reg_wdata[1:0]) | wake_set;
			end else begin
				wake_flag_reg <= wake_flag_reg | wake_set;
			end
		end
	end

	// event-counter path: counts timer-route edges only, wraps, reset only by reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wake_count_reg <= CANIRQ_WCNT_RST[WAKE_CW-1:0];
		end else if (clk_en && wake_set[CANIRQ_WAKE_TMR]) begin
			wake_count_reg <= wake_count_reg + 1'b1;
		end
	end

	// ======================================================
	// read path, data valid the cycle after the strobe
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= '0;
		end else if (clk_en) begin
			if (reg_rd) begin
				case (reg_addr)
					CANIRQ_OFS_CTRL: rdata_reg <= {30'h0, can_control_one_reg};
					CANIRQ_OFS_SLOT_STAT: rdata_reg <= pad_word(slot_irq_status_reg);
					CANIRQ_OFS_ERR_STAT: rdata_reg <= {29'h0, error_irq_status_reg};
					CANIRQ_OFS_SLOT_MASK: rdata_reg <= pad_word(slot_irq_mask_reg);
					CANIRQ_OFS_ERR_MASK: rdata_reg <= {29'h0, error_irq_mask_reg};
					CANIRQ_OFS_GRP_FLAG: rdata_reg <= {29'h0, group_flag_reg};
					CANIRQ_OFS_GRP_EN: rdata_reg <= {29'h0, group_request_enable_reg};
					CANIRQ_OFS_PENDING: rdata_reg <= {29'h0, pending_reg};
					CANIRQ_OFS_WAKE: begin
						rdata_reg <= '0;
						rdata_reg[CANIRQ_WAKE_CNT_LSB +: WAKE_CW] <= wake_count_reg;
						rdata_reg[1:0] <= wake_flag_reg;
					end
					CANIRQ_OFS_SLOT_KIND: rdata_reg <= pad_word(slot_kind_rx_reg);
					default: rdata_reg <= '0;
				endcase
			end else begin
				rdata_reg <= '0;
			end
		end
	end

	// ======================================================
	// outputs
	assign reg_rdata = rdata_reg;
	assign combined_request = !split_mode && comb_level;
	assign receive_request = hold_reg[CANIRQ_GRP_RX];
	assign transmit_request = hold_reg[CANIRQ_GRP_TX];
	assign error_request = hold_reg[CANIRQ_GRP_ERR];
	assign group_request_flag = group_flag_reg;
	assign pending_request_bit = pending_reg;
	assign wake_request = |wake_flag_reg;

endmodule // canirq_top

// ### sim/canirq_engine_model.sv
// model: protocol engine event pulses and the shared receive pin
`timescale 1ns/1ps
module canirq_engine_model #(
	parameter int SLOTS = 16
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic fire,
	input wire logic [2:0] fire_kind,
	input wire logic [$clog2(SLOTS)-1:0] fire_slot,
	input wire logic pin_low,
	output logic [SLOTS-1:0] slot_tx_done,
	output logic [SLOTS-1:0] slot_rx_done,
	output logic [2:0] err_evt,
	output logic can_receive_pin
);
	// idle bus is recessive, so the pin rests high
	assign can_receive_pin = !pin_low;

	// ======================================================
	// one-cycle event pulses
	// completion events per slot
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			slot_tx_done <= '0;
			slot_rx_done <= '0;
			err_evt <= '0;
		end else begin
			slot_tx_done <= '0;
			slot_rx_done <= '0;
			err_evt <= '0;
			if (fire) begin
				case (fire_kind)
					3'h0: slot_tx_done[fire_slot] <= 1'b1;
					3'h1: slot_rx_done[fire_slot] <= 1'b1;
					// kinds 2..4: bus error, passive, bus-off
					default: err_evt[fire_kind-3'h2] <= 1'b1;
				endcase
			end
		end
	end
endmodule // canirq_engine_model

// ### sim/canirq_top_monitor.sv
// checker: request, flag and pending relations at the aggregator ports
`timescale 1ns/1ps
module canirq_top_monitor #(
	parameter int SLOTS = 16
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [canirq_pkg::CANIRQ_AW-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [SLOTS-1:0] slot_rx_done,
	input wire logic combined_request,
	input wire logic receive_request,
	input wire logic transmit_request,
	input wire logic error_request,
	input wire logic [canirq_pkg::CANIRQ_GROUPS-1:0] group_request_flag,
	input wire logic [canirq_pkg::CANIRQ_GROUPS-1:0] pending_request_bit
);
	import canirq_pkg::*;
	default clocking mon_cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	// ======================================================
	// assertions
	rx_sets_flag_a: assert property ($rose(receive_request) |-> group_request_flag[0])
		else $error("receive request rose without its flag");
	tx_sets_flag_a: assert property ($rose(transmit_request) |-> group_request_flag[1])
		else $error("transmit request rose without its flag");
	err_sets_flag_a: assert property ($rose(error_request) |-> group_request_flag[2])
		else $error("error request rose without its flag");
	comb_all_flags_a: assert property ($rose(combined_request) && clk_en
		|=> &group_request_flag)
		else $error("combined edge did not set all flags");
	// only software clears a flag
	flag_sticky_a: assert property (|($past(group_request_flag) & ~group_request_flag) |->
		$past(reg_wr && clk_en && reg_addr == CANIRQ_OFS_GRP_FLAG))
		else $error("group flag fell without a write");
	comb_hold_a: assert property (combined_request && $past(combined_request) &&
		$past(combined_request, 2) |-> !(|(group_request_flag & ~$past(group_request_flag)))
		&& !(|(pending_request_bit & ~$past(pending_request_bit))))
		else $error("held combined request changed flags");
	err_hold_a: assert property (error_request && $past(error_request) &&
		$past(error_request, 2) |-> !$rose(group_request_flag[2]) && !$rose(pending_request_bit[2]))
		else $error("held error request changed its flag");
	rx_rearm_a: assert property (receive_request && !group_request_flag[0] &&
		slot_rx_done == '0 && clk_en |=> !receive_request)
		else $error("receive request did not re-arm");

	cover property ($rose(combined_request));
	cover property ($rose(receive_request) ##[1:40] $rose(transmit_request));
	cover property ($rose(error_request));
endmodule // canirq_top_monitor

bind canirq_top canirq_top_monitor #(.SLOTS(SLOTS)) u_mon (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.clk_en(clk_en),
	.reg_addr(reg_addr),
	.reg_wr(reg_wr),
	.slot_rx_done(slot_rx_done),
	.combined_request(combined_request),
	.receive_request(receive_request),
	.transmit_request(transmit_request),
	.error_request(error_request),
	.group_request_flag(group_request_flag),
	.pending_request_bit(pending_request_bit)
);

// ### sim/canirq_top_bench.sv
// bench: register-level tests of the can interrupt aggregator
`timescale 1ns/1ps
module canirq_top_bench;
	import canirq_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n;
	logic clk_en = 1'b1;
	logic [CANIRQ_AW-1:0] reg_addr = '0;
	logic [CANIRQ_DW-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [CANIRQ_DW-1:0] reg_rdata;
	logic [CANIRQ_SLOTS-1:0] slot_tx_done;
	logic [CANIRQ_SLOTS-1:0] slot_rx_done;
	logic [2:0] err_evt;
	wire bus_error_evt = err_evt[CANIRQ_ERR_BUS];
	wire err_passive_evt = err_evt[CANIRQ_ERR_PASSIVE];
	wire bus_off_evt = err_evt[CANIRQ_ERR_BUSOFF];
	logic can_receive_pin;
	logic combined_request;
	logic receive_request;
	logic transmit_request;
	logic error_request;
	logic [CANIRQ_GROUPS-1:0] group_request_flag;
	logic [CANIRQ_GROUPS-1:0] pending_request_bit;
	logic wake_request;
	logic fire = 1'b0;
	logic [2:0] fire_kind = '0;
	logic [3:0] fire_slot = '0;
	logic pin_low = 1'b0;
	int num_errors = 0;
	int comparisons = 0;

	always #4 clk_sys = ~clk_sys;

	canirq_top #(.SLOTS(CANIRQ_SLOTS), .WAKE_CW(CANIRQ_WAKE_CW)) uut (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.slot_tx_done(slot_tx_done),
		.slot_rx_done(slot_rx_done),
		.bus_error_evt(bus_error_evt),
		.err_passive_evt(err_passive_evt),
		.bus_off_evt(bus_off_evt),
		.can_receive_pin(can_receive_pin),
		.combined_request(combined_request),
		.receive_request(receive_request),
		.transmit_request(transmit_request),
		.error_request(error_request),
		.group_request_flag(group_request_flag),
		.pending_request_bit(pending_request_bit),
		.wake_request(wake_request)
	);
	canirq_engine_model #(.SLOTS(CANIRQ_SLOTS)) u_engine (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.fire(fire),
		.fire_kind(fire_kind),
		.fire_slot(fire_slot),
		.pin_low(pin_low),
		.slot_tx_done(slot_tx_done),
		.slot_rx_done(slot_rx_done),
		.err_evt(err_evt),
		.can_receive_pin(can_receive_pin)
	);

	// ======================================================
	// tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	// kinds: 0 tx, 1 rx, 2 bus error, 3 passive, 4 bus-off
	task automatic ev(input logic [2:0] k, input logic [3:0] s);
		@(posedge clk_sys);
		fire <= 1'b1;
		fire_kind <= k;
		fire_slot <= s;
		@(posedge clk_sys);
		fire <= 1'b0;
		// longest event path is two cycles
		repeat (4) @(posedge clk_sys);
		#1;
	endtask
	task automatic pin_fall();
		@(posedge clk_sys);
		pin_low <= 1'b1;
		// synchroniser plus edge detect, with margin
		repeat (10) @(posedge clk_sys);
		pin_low <= 1'b0;
		repeat (6) @(posedge clk_sys);
		#1;
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ======================================================
	// tests
	initial begin
		rst_n = 1'b0;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		// every register clear, unmapped place reads zero
		for (int i = 0; i <= 36; i += 4) rd(i[7:0], 32'h0);
		rd(8'h40, 32'h0);
		$display("test reset values done");
		wr(CANIRQ_OFS_CTRL, 32'h1);
		wr(CANIRQ_OFS_SLOT_MASK, 32'hffff);
		wr(CANIRQ_OFS_ERR_MASK, 32'h7);
		wr(CANIRQ_OFS_GRP_EN, 32'h7);
		ev(3'h1, 4'h3);
		chk(receive_request, 1'b1);
		rd(CANIRQ_OFS_SLOT_STAT, 32'h0008);
		rd(CANIRQ_OFS_GRP_FLAG, 32'h1);
		// read data stands one cycle only
		@(posedge clk_sys);
		#1 chk(reg_rdata, 32'h0);
		ev(3'h0, 4'hf);
		chk(transmit_request, 1'b1);
		rd(CANIRQ_OFS_SLOT_STAT, 32'h8008);
		rd(CANIRQ_OFS_SLOT_KIND, 32'h0008);
		ev(3'h2, 4'h0);
		chk(error_request, 1'b1);
		rd(CANIRQ_OFS_PENDING, 32'h7);
		wr(CANIRQ_OFS_GRP_FLAG, 32'h3);
		wr(CANIRQ_OFS_PENDING, 32'h3);
		ev(3'h3, 4'h0);
		ev(3'h4, 4'h0);
		rd(CANIRQ_OFS_ERR_STAT, 32'h7);
		rd(CANIRQ_OFS_GRP_FLAG, 32'h3);
		rd(CANIRQ_OFS_PENDING, 32'h3);
		wr(CANIRQ_OFS_ERR_STAT, 32'h0);
		ev(3'h2, 4'h0);
		rd(CANIRQ_OFS_GRP_FLAG, 32'h7);
		wr(CANIRQ_OFS_GRP_FLAG, 32'h6);
		repeat (2) @(posedge clk_sys);
		#1 chk(receive_request, 1'b0);
		ev(3'h1, 4'h3);
		rd(CANIRQ_OFS_GRP_FLAG, 32'h7);
		rd(CANIRQ_OFS_SLOT_STAT, 32'h8008);
		$display("test split mode done");
		wr(CANIRQ_OFS_SLOT_STAT, 32'h0);
		wr(CANIRQ_OFS_ERR_STAT, 32'h0);
		wr(CANIRQ_OFS_GRP_FLAG, 32'h0);
		wr(CANIRQ_OFS_PENDING, 32'h0);
		wr(CANIRQ_OFS_GRP_EN, 32'h5);
		wr(CANIRQ_OFS_CTRL, 32'h0);
		wr(CANIRQ_OFS_SLOT_MASK, 32'hfffe);
		ev(3'h1, 4'h0);
		chk(combined_request, 1'b0);
		ev(3'h0, 4'h1);
		chk(combined_request, 1'b1);
		chk({receive_request, transmit_request, error_request}, 3'h0);
		chk(group_request_flag, 3'h7);
		chk(pending_request_bit, 3'h5);
		rd(CANIRQ_OFS_GRP_FLAG, 32'h7);
		rd(CANIRQ_OFS_PENDING, 32'h5);
		wr(CANIRQ_OFS_PENDING, 32'h0);
		ev(3'h0, 4'h2);
		rd(CANIRQ_OFS_PENDING, 32'h0);
		wr(CANIRQ_OFS_GRP_FLAG, 32'h0);
		ev(3'h2, 4'h0);
		rd(CANIRQ_OFS_GRP_FLAG, 32'h0);
		wr(CANIRQ_OFS_SLOT_STAT, 32'h0);
		wr(CANIRQ_OFS_ERR_STAT, 32'h0);
		ev(3'h1, 4'h5);
		rd(CANIRQ_OFS_GRP_FLAG, 32'h7);
		$display("test combined mode done");
		// a write while frozen must not land
		@(posedge clk_sys);
		clk_en <= 1'b0;
		wr(CANIRQ_OFS_GRP_EN, 32'h0);
		clk_en <= 1'b1;
		rd(CANIRQ_OFS_GRP_EN, 32'h5);
		$display("test clock enable done");
		pin_fall();
		chk(wake_request, 1'b1);
		rd(CANIRQ_OFS_WAKE, 32'h0101);
		wr(CANIRQ_OFS_CTRL, 32'h2);
		// external route: flag only, the event counter stays put
		pin_fall();
		rd(CANIRQ_OFS_WAKE, 32'h0103);
		$display("test wake-up done");
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		#1 chk({combined_request, group_request_flag, pending_request_bit, wake_request}, 8'h0);
		rd(CANIRQ_OFS_SLOT_STAT, 32'h0);
		rd(CANIRQ_OFS_WAKE, 32'h0);
		$display("test reset mid-run done");
		conclude();
	end

	// tests need a few hundred cycles; this bound is well above that
	initial begin
		#100000;
		num_errors++;
		conclude();
	end
endmodule // canirq_top_bench
